// *** inc/cix_pkg.sv ***
package cix_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int WORD_W = 14;
  localparam int PC_W = 15;
  localparam int JMP_W = 11;
  localparam int LATH_W = 7;
  localparam int LATH_LO = 3;
  localparam int LATH_HI = 6;
  localparam int FILE_DEPTH = 128;

  // opcode fields of the 14-bit word
  localparam int OP6_HI = 13;
  localparam int OP6_LO = 8;
  localparam int OP3_HI = 13;
  localparam int OP3_LO = 11;
  localparam int DEST_BIT = 7;

  localparam logic [5:0] OP_DECREMENT_SKIP_ON_ZERO = 6'h0b;
  localparam logic [5:0] OP_INCREMENT_FILE = 6'h0a;
  localparam logic [5:0] OP_INCREMENT_SKIP_ON_ZERO = 6'h0f;
  localparam logic [5:0] OP_ORLIT = 6'h38;
  localparam logic [5:0] OP_ORFILE = 6'h04;
  localparam logic [2:0] OP_JUMP = 3'h5;

  localparam logic [DATA_W-1:0] ONE8 = 8'h01;
  localparam logic [DATA_W-1:0] ZERO8 = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic DEST_ACC = 1'b0;

  typedef enum logic [1:0] {
    CIX_EXEC = 2'b01,
    CIX_FLUSH = 2'b10
  } cix_state_e;
endpackage : cix_pkg

// *** verification/cix_core_monitor.sv ***
`timescale 1ns/1ps
module cix_core_monitor (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic [cix_pkg::WORD_W-1:0] I_INSTR,
  input wire logic [cix_pkg::LATH_W-1:0] I_PC_LATCH_HIGH,
  input wire logic [cix_pkg::PC_W-1:0] O_PROGRAM_COUNTER,
  input wire logic [cix_pkg::DATA_W-1:0] O_ACC,
  input wire logic O_ZERO_FLAG,
  input wire logic O_BUSY,
  input wire logic O_SKIP_PENDING,
  input wire logic O_UNKNOWN_OP
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);
  // a jump is the only flush whose pc is not the old pc plus one
  sequence jumped_s;
    O_BUSY && O_PROGRAM_COUNTER != $past(O_PROGRAM_COUNTER) + 15'h0001;
  endsequence
  a_busy_mirror: assert property (O_BUSY == O_SKIP_PENDING) else $error("busy and skip differ");
  a_flush_one_cycle: assert property (O_BUSY |=> !O_BUSY) else $error("flush too long");
  a_flush_holds_acc: assert property (O_BUSY |=> $stable(O_ACC) && $stable(O_ZERO_FLAG)) else $error("flushed word ran");
  a_pc_steps_one: assert property (!O_BUSY && $changed(O_PROGRAM_COUNTER) |->
    O_PROGRAM_COUNTER == $past(O_PROGRAM_COUNTER) + 15'h0001) else $error("pc step wrong");
  // input sync depth is two flops, so accept either alignment of the source sample
  a_jump_high_bits: assert property (jumped_s |-> O_PROGRAM_COUNTER[14:11] == $past(I_PC_LATCH_HIGH[6:3], 3) ||
    O_PROGRAM_COUNTER[14:11] == $past(I_PC_LATCH_HIGH[6:3], 4)) else $error("jump high bits wrong");
  a_jump_low_bits: assert property (jumped_s |-> O_PROGRAM_COUNTER[10:0] == $past(I_INSTR[10:0], 3) ||
    O_PROGRAM_COUNTER[10:0] == $past(I_INSTR[10:0], 4)) else $error("jump low bits wrong");
  a_jump_keeps_acc: assert property (jumped_s |-> $stable(O_ACC)) else $error("jump changed acc");
  a_skip_keeps_zero: assert property (O_BUSY |-> $stable(O_ZERO_FLAG)) else $error("skip changed zero");
  c_flush: cover property (O_BUSY);
  c_jump: cover property (jumped_s);
  c_unknown: cover property (O_UNKNOWN_OP);
  c_zero: cover property (O_ZERO_FLAG);
endmodule : cix_core_monitor
bind cix_core cix_core_monitor mon_u (.I_REF_CLK, .I_RESETN, .I_INSTR, .I_PC_LATCH_HIGH, .O_PROGRAM_COUNTER,
  .O_ACC, .O_ZERO_FLAG, .O_BUSY, .O_SKIP_PENDING, .O_UNKNOWN_OP);

// *** verification/cix_core_test.sv ***
`timescale 1ns/1ps
module cix_core_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [cix_pkg::WORD_W-1:0] instr = 14'h0000;
  logic valid = 1'b0;
  logic [cix_pkg::LATH_W-1:0] lath = 7'h5a;
  logic [cix_pkg::PC_W-1:0] pc;
  logic [cix_pkg::DATA_W-1:0] acc;
  logic zf, busy, unk, skp;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  cix_core dut_u (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_INSTR(instr), .I_INSTR_VALID(valid),
    .I_PC_LATCH_HIGH(lath), .O_PROGRAM_COUNTER(pc), .O_ACC(acc), .O_ZERO_FLAG(zf), .O_BUSY(busy),
    .O_SKIP_PENDING(skp), .O_UNKNOWN_OP(unk));
  initial forever #4 clk = ~clk;
  // whole run is under 150 cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // two=1 follows the word with an or of 0x80, which shows whether it was flushed
  task automatic ex(input logic [13:0] w, input logic two, input logic [7:0] ea, input logic ez,
    input logic eb, input logic eu, input logic [14:0] ep);
    logic sb, su, sk;
    sb = 1'b0;
    su = 1'b0;
    sk = 1'b0;
    instr = w;
    valid = 1'b1;
    @(posedge clk);
    #1;
    if (two) begin
      instr = {cix_pkg::OP_ORLIT, 8'h80};
      @(posedge clk);
      #1;
    end
    valid = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      sb |= (busy === 1'b1);
      su |= (unk === 1'b1);
      sk |= (skp === 1'b1);
    end
    chk({7'h00, acc}, {7'h00, ea}, "acc");
    chk({14'h0000, zf}, {14'h0000, ez}, "zero flag");
    chk({14'h0000, sb}, {14'h0000, eb}, "flush");
    chk({14'h0000, su}, {14'h0000, eu}, "unknown");
    chk({14'h0000, sk}, {14'h0000, eb}, "skip pending");
    chk(pc, ep, "pc");
  endtask : ex
  task automatic t_or_route();
    ex({cix_pkg::OP_ORLIT, 8'hff}, 0, 8'hff, 0, 0, 0, 15'h0001);
    ex({cix_pkg::OP_ORFILE, 8'h85}, 0, 8'hff, 0, 0, 0, 15'h0002);
  endtask : t_or_route
  task automatic t_inc();
    ex({cix_pkg::OP_INCREMENT_FILE, 8'h85}, 0, 8'hff, 1, 0, 0, 15'h0003);
    ex({cix_pkg::OP_INCREMENT_SKIP_ON_ZERO, 8'h05}, 0, 8'h01, 1, 0, 0, 15'h0004);
    ex({cix_pkg::OP_INCREMENT_FILE, 8'h05}, 0, 8'h01, 0, 0, 0, 15'h0005);
  endtask : t_inc
  task automatic t_skips();
    ex({cix_pkg::OP_DECREMENT_SKIP_ON_ZERO, 8'h85}, 1, 8'h81, 0, 0, 0, 15'h0007);
    ex({cix_pkg::OP_INCREMENT_SKIP_ON_ZERO, 8'h85}, 1, 8'h81, 0, 1, 0, 15'h0009);
    ex({cix_pkg::OP_INCREMENT_FILE, 8'h85}, 0, 8'h81, 0, 0, 0, 15'h000a);
    ex({cix_pkg::OP_DECREMENT_SKIP_ON_ZERO, 8'h85}, 1, 8'h81, 0, 1, 0, 15'h000c);
    ex({cix_pkg::OP_DECREMENT_SKIP_ON_ZERO, 8'h05}, 0, 8'hff, 0, 0, 0, 15'h000d);
  endtask : t_skips
  task automatic t_or_zero();
    ex({cix_pkg::OP_ORFILE, 8'h85}, 0, 8'hff, 0, 0, 0, 15'h000e);
    ex({cix_pkg::OP_INCREMENT_FILE, 8'h05}, 0, 8'h00, 1, 0, 0, 15'h000f);
    ex({cix_pkg::OP_ORLIT, 8'h00}, 0, 8'h00, 1, 0, 0, 15'h0010);
    ex({cix_pkg::OP_ORFILE, 8'h05}, 0, 8'hff, 0, 0, 0, 15'h0011);
  endtask : t_or_zero
  task automatic t_jumps();
    ex(14'h0000, 0, 8'hff, 0, 0, 1, 15'h0012);
    ex({cix_pkg::OP_JUMP, 11'h7a5}, 1, 8'hff, 0, 1, 0, 15'h5fa6);
    lath = 7'h07;
    ex({cix_pkg::OP_JUMP, 11'h7ff}, 0, 8'hff, 0, 1, 0, 15'h07ff);
  endtask : t_jumps
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_or_route();
    t_inc();
    t_skips();
    t_or_zero();
    t_jumps();
    print_verdict();
  end
endmodule : cix_core_test

// *** verilog/cix_core.sv ***
`timescale 1ns/1ps
// Contract
// - decrement-skip subtracts one from file register at 7-bit address
// - decrement-skip zero result turns next instruction into no-operation
// - destination bit 0 writes accumulator, 1 writes back file register
// - jump loads 11-bit immediate into program counter bits 10..0
// - jump fills program counter bits 14..11 from latch-high bits 6..3
// - jump takes two cycles and leaves all flags unchanged
// - increment adds one, routes by destination, updates only zero flag
// - increment-skip adds one, no flags, skips next on zero result
// - or-literal ors accumulator with 8-bit immediate into accumulator, zero flag
// - or-file ors accumulator with file register, routes by destination, zero flag
module cix_core (
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic [cix_pkg::WORD_W-1:0] I_INSTR,
  input wire logic I_INSTR_VALID,
  input wire logic [cix_pkg::LATH_W-1:0] I_PC_LATCH_HIGH,
  output logic [cix_pkg::PC_W-1:0] O_PROGRAM_COUNTER,
  output logic [cix_pkg::DATA_W-1:0] O_ACC,
  output logic O_ZERO_FLAG,
  output logic O_BUSY,
  output logic O_SKIP_PENDING,
  output logic O_UNKNOWN_OP
);
  cix_pkg::cix_state_e state_r;
  cix_pkg::cix_state_e state_nxt;

  logic [cix_pkg::WORD_W-1:0] instr_s;
  logic valid_s;
  logic [cix_pkg::LATH_W-1:0] lath_s;

  logic [cix_pkg::DATA_W-1:0] file_rd;
  logic [cix_pkg::DATA_W-1:0] result;
  logic file_we;
  logic acc_we;
  logic z_we;
  logic skip_req;
  logic jump_req;
  logic known_op;
  logic exec_ok;

  logic [5:0] op6;
  logic [2:0] op3;
  logic dest;
  logic [cix_pkg::FADDR_W-1:0] faddr;
  logic [cix_pkg::DATA_W-1:0] lit;
  logic [cix_pkg::JMP_W-1:0] jtarget;

  // instruction word and latch come from outside this clock, so they are synchronised;
  // the bus is assumed to stay stable across the two-stage delay
  cix_sync2 #(
    .W(cix_pkg::WORD_W + 1 + cix_pkg::LATH_W)
  ) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESETN),
    .i_d({I_INSTR, I_INSTR_VALID, I_PC_LATCH_HIGH}),
    .o_q({instr_s, valid_s, lath_s})
  );

  assign op6 = instr_s[cix_pkg::OP6_HI:cix_pkg::OP6_LO];
  assign op3 = instr_s[cix_pkg::OP3_HI:cix_pkg::OP3_LO];
  assign dest = instr_s[cix_pkg::DEST_BIT];
  assign faddr = instr_s[cix_pkg::FADDR_W-1:0];
  assign lit = instr_s[cix_pkg::DATA_W-1:0];
  assign jtarget = instr_s[cix_pkg::JMP_W-1:0];

  cix_file_ram u_file (
    .i_clk(I_REF_CLK),
    .i_addr(faddr),
    .i_we(file_we),
    .i_wdata(result),
    .o_rdata(file_rd)
  );

  // only execute in the exec state; a flush cycle discards the fetched word
  assign exec_ok = valid_s && (state_r == cix_pkg::CIX_EXEC);

  always_comb begin
    result = cix_pkg::ZERO8;
    acc_we = 1'b0;
    file_we = 1'b0;
    z_we = 1'b0;
    skip_req = 1'b0;
    jump_req = 1'b0;
    known_op = 1'b1;
    if (op3 == cix_pkg::OP_JUMP) begin
      jump_req = exec_ok;
    end else if (op6 == cix_pkg::OP_DECREMENT_SKIP_ON_ZERO) begin
      result = file_rd - cix_pkg::ONE8;
      skip_req = exec_ok && (result == cix_pkg::ZERO8);
      acc_we = exec_ok && (dest == cix_pkg::DEST_ACC);
      file_we = exec_ok && (dest != cix_pkg::DEST_ACC);
    end else if (op6 == cix_pkg::OP_INCREMENT_FILE) begin
      result = file_rd + cix_pkg::ONE8;
      acc_we = exec_ok && (dest == cix_pkg::DEST_ACC);
      file_we = exec_ok && (dest != cix_pkg::DEST_ACC);
      z_we = exec_ok;
    end else if (op6 == cix_pkg::OP_INCREMENT_SKIP_ON_ZERO) begin
      result = file_rd + cix_pkg::ONE8;
      skip_req = exec_ok && (result == cix_pkg::ZERO8);
      acc_we = exec_ok && (dest == cix_pkg::DEST_ACC);
      file_we = exec_ok && (dest != cix_pkg::DEST_ACC);
    end else if (op6 == cix_pkg::OP_ORLIT) begin
      result = O_ACC | lit;
      acc_we = exec_ok;
      z_we = exec_ok;
    end else if (op6 == cix_pkg::OP_ORFILE) begin
      result = O_ACC | file_rd;
      acc_we = exec_ok && (dest == cix_pkg::DEST_ACC);
      file_we = exec_ok && (dest != cix_pkg::DEST_ACC);
      z_we = exec_ok;
    end else begin
      known_op = 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cix_pkg::CIX_EXEC: begin
        if (skip_req || jump_req) begin
          state_nxt = cix_pkg::CIX_FLUSH;
        end
      end
      cix_pkg::CIX_FLUSH: begin
        state_nxt = cix_pkg::CIX_EXEC;
      end
      default: begin
        state_nxt = cix_pkg::CIX_EXEC;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r <= cix_pkg::CIX_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PROGRAM_COUNTER <= cix_pkg::PC_RESET;
    end else if (jump_req) begin
      O_PROGRAM_COUNTER <= {lath_s[cix_pkg::LATH_HI:cix_pkg::LATH_LO], jtarget};
    end else if (valid_s) begin
      // a skipped word still advances the counter, as a no-operation would
      O_PROGRAM_COUNTER <= O_PROGRAM_COUNTER + cix_pkg::PC_STEP;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ACC <= cix_pkg::ZERO8;
    end else if (acc_we) begin
      O_ACC <= result;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ZERO_FLAG <= 1'b0;
    end else if (z_we) begin
      O_ZERO_FLAG <= (result == cix_pkg::ZERO8);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_UNKNOWN_OP <= 1'b0;
    end else begin
      O_UNKNOWN_OP <= exec_ok && !known_op;
    end
  end

  assign O_BUSY = (state_r == cix_pkg::CIX_FLUSH);
  assign O_SKIP_PENDING = O_BUSY;
endmodule : cix_core

// *** verilog/cix_file_ram.sv ***
`timescale 1ns/1ps
module cix_file_ram (
  input wire logic i_clk,
  input wire logic [cix_pkg::FADDR_W-1:0] i_addr,
  input wire logic i_we,
  input wire logic [cix_pkg::DATA_W-1:0] i_wdata,
  output logic [cix_pkg::DATA_W-1:0] o_rdata
);
  // no reset: file contents are undefined after power-up, software initialises them
  logic [cix_pkg::DATA_W-1:0] mem [cix_pkg::FILE_DEPTH];

  assign o_rdata = mem[i_addr];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule : cix_file_ram

// *** verilog/cix_sync2.sv ***
`timescale 1ns/1ps
module cix_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : cix_sync2
